/* File: logic/gpexr_params.svh */
// Constants of the I/O expander bus responder.
`ifndef GPEXR_PARAMS_SVH
`define GPEXR_PARAMS_SVH
`define GPEXR_ADDR_FIXED  5'h1d
`define GPEXR_GCALL_ADDR  8'h00
`define GPEXR_SWRST_BYTE  8'h06
`define GPEXR_PTR_RESET   8'h00
`define GPEXR_ONES        8'hff
`define GPEXR_ZEROS       8'h00
`define GPEXR_BYTE_BITS   4'h8
`define GPEXR_LAST_TX_BIT 4'h7
`define GPEXR_EXT_BIT     6
`define GPEXR_LOW_MSB     3
`define GPEXR_SLOT_EXT    4
`define GPEXR_SLOTS       32
`define GPEXR_FIFO_DEPTH  16
`define GPEXR_PIN_LOW     8'h00
`define GPEXR_PIN_HIGH    8'h01
`define GPEXR_DRV_VAL_L   8'h02
`define GPEXR_DRV_VAL_H   8'h03
`define GPEXR_INV_L       8'h04
`define GPEXR_INV_H       8'h05
`define GPEXR_DIR_L       8'h06
`define GPEXR_DIR_H       8'h07
`define GPEXR_DRV_LVL_A   8'h40
`define GPEXR_DRV_LVL_B   8'h41
`define GPEXR_DRV_LVL_C   8'h42
`define GPEXR_DRV_LVL_D   8'h43
`define GPEXR_HOLD_L      8'h44
`define GPEXR_HOLD_H      8'h45
`define GPEXR_RES_ON_L    8'h46
`define GPEXR_RES_ON_H    8'h47
`define GPEXR_RES_DIR_L   8'h48
`define GPEXR_RES_DIR_H   8'h49
`define GPEXR_IRQ_BLK_L   8'h4a
`define GPEXR_IRQ_BLK_H   8'h4b
`define GPEXR_IRQ_FLG_L   8'h4c
`define GPEXR_IRQ_FLG_H   8'h4d
`define GPEXR_OSTAGE      8'h4f
`endif

/* File: logic/gpexr_pkg.sv */
// Types shared by the I/O expander bus responder.
package gpexr_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_RX, PH_RX_ACK, PH_TX, PH_TX_ACK, PH_WAIT} gpexr_phase_type;
  typedef enum logic [2:0] {K_ADDR, K_CMD, K_DATA, K_GC, K_GC_DONE, K_TX} gpexr_kind_type;
  typedef struct packed {
    logic [4:0] slot;
    logic [7:0] data;
  } gpexr_wr_type;
  typedef struct packed {
    logic       legal;
    logic       wr;
    logic [7:0] rst;
  } gpexr_info_type;
  typedef struct packed {
    logic [15:0] drive_value;
    logic [15:0] invert;
    logic [15:0] direction;
    logic [31:0] drive_level;
    logic [15:0] hold_input;
    logic [15:0] resistor_on;
    logic [15:0] resistor_dir;
    logic [15:0] irq_block;
    logic [7:0]  output_stage_type;
  } gpexr_cfg_type;
  typedef struct packed {
    logic                  scl_m;
    logic                  scl_s;
    logic                  scl_p;
    logic                  sda_m;
    logic                  sda_s;
    logic                  sda_p;
    logic [1:0]            strap_m;
    logic [1:0]            strap_s;
    logic [15:0]           pin_m;
    logic [15:0]           pin_s;
    gpexr_phase_type       phase;
    gpexr_kind_type        kind;
    logic [7:0]            shreg;
    logic [3:0]            bitcnt;
    logic                  sda_pull;
    logic                  gc_ok;
    logic [7:0]            ptr;
    logic [31:0][7:0]      bank;
    logic [1:0]            irq_clr;
  } gpexr_state_type;
endpackage

/* File: logic/gpexr_top.sv */
// Bus responder with register file and write FIFO for a 16-bit I/O expander.
// Operation
// R1: Controller starts a transfer only while the bus is idle.
// R2: SDA falling while SCL high is a start; it opens an address byte.
// R3: Address byte arrives MSB first with the direction bit last.
// R4: Device answers at 74h..77h, low two bits taken from the straps.
// R5: Direction bit 1 means read, 0 means write.
// R6: A matching address is acknowledged by SDA low over the ninth high phase.
// R7: Straps stay steady from start to stop of each transfer.
// R8: SDA changes only while SCL is low; changes at SCL high are conditions.
// R9: SDA rising while SCL high is a stop; it ends the transfer.
// R10: Any number of bytes, each eight bits plus one acknowledge bit.
// R11: Transmitter releases SDA for the acknowledge; acknowledger holds it low.
// R12: Device acknowledges each received byte; controller all read bytes but last.
// R13: Controller ends a read with a NACK; device then releases SDA.
// R14: First byte of a write is the command, stored as register pointer.
// R15: Pointer bit 6 with low bits selects extended or basic registers.
// R16: Pointer holds across transfers until a new command byte.
// R17: Every reset kind clears the pointer to 00h.
// R18: Codes 00-07 select input, output, polarity, direction per port.
// R19: Codes 40-4F select drive, latch, pull, mask, status, output stage.
// R20: Status registers are read-only zero at reset; masks reset to ones.
// R21: Register reset values as tabled; input registers follow the pins.
// R22: General call, single byte 06h, then stop performs software reset.
// R23: Reset low forces registers and the bus machine to default.
// R24: Reading an input port clears its interrupt at the acknowledge rise.
// R25: Unmapped codes read zero and writes to them are discarded.
`timescale 1ns/1ns
`include "gpexr_params.svh"

module gpexr_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = `GPEXR_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } gpexr_fifo_st_type;
  gpexr_fifo_st_type st_r, st_nxt;
  logic              do_push;
  logic              do_pop;

  assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data  = st_r.mem[st_r.rp];
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (do_push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (do_pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    if (flush) begin
      st_nxt.wp  = '0;
      st_nxt.rp  = '0;
      st_nxt.cnt = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

module gpexr_top
  import gpexr_pkg::*;
(
  // Clock and synchronous reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Serial bus, data pin is open drain
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Address straps
  input  wire logic        addr_strap_lsb,
  input  wire logic        addr_strap_msb,
  // Pin levels and interrupt state from the port logic
  input  wire logic [7:0]  port_zero_pins,
  input  wire logic [7:0]  port_one_pins,
  input  wire logic [15:0] irq_flags_in,
  // Register contents and interrupt clear towards the port logic
  output gpexr_cfg_type    cfg_out,
  output logic [1:0]       irq_read_clear
);
  function automatic logic [4:0] slot_of(input logic [7:0] p);
    return {p[`GPEXR_EXT_BIT], p[`GPEXR_LOW_MSB:0]};
  endfunction

  function automatic gpexr_info_type info_of(input logic [7:0] p);
    gpexr_info_type r;
    r = '{legal: 1'b1, wr: 1'b1, rst: `GPEXR_ONES};
    unique case (p)
      `GPEXR_PIN_LOW, `GPEXR_PIN_HIGH,
      `GPEXR_IRQ_FLG_L, `GPEXR_IRQ_FLG_H: begin
        r.wr  = 1'b0;
        r.rst = `GPEXR_ZEROS;
      end
      `GPEXR_DRV_VAL_L, `GPEXR_DRV_VAL_H, `GPEXR_DIR_L, `GPEXR_DIR_H,
      `GPEXR_DRV_LVL_A, `GPEXR_DRV_LVL_B, `GPEXR_DRV_LVL_C, `GPEXR_DRV_LVL_D,
      `GPEXR_RES_DIR_L, `GPEXR_RES_DIR_H, `GPEXR_IRQ_BLK_L, `GPEXR_IRQ_BLK_H: begin
        r.rst = `GPEXR_ONES;
      end
      `GPEXR_INV_L, `GPEXR_INV_H, `GPEXR_HOLD_L, `GPEXR_HOLD_H,
      `GPEXR_RES_ON_L, `GPEXR_RES_ON_H, `GPEXR_OSTAGE: begin
        r.rst = `GPEXR_ZEROS;
      end
      default: begin
        r = '{legal: 1'b0, wr: 1'b0, rst: `GPEXR_ZEROS};
      end
    endcase
    return r;
  endfunction

  function automatic logic [31:0][7:0] bank_reset();
    logic [31:0][7:0] b;
    logic [4:0]       s;
    b = '0;
    for (int i = 0; i < `GPEXR_SLOTS; i++) begin
      s = 5'(i);
      b[i] = info_of({1'b0, s[`GPEXR_SLOT_EXT], 2'b00, s[`GPEXR_LOW_MSB:0]}).rst;
    end
    return b;
  endfunction

  localparam logic [31:0][7:0] BANK_RST = bank_reset();

  gpexr_state_type state_r, state_nxt;
  logic            scl_rise;
  logic            scl_fall;
  logic            ev_start;
  logic            ev_stop;
  logic            load_ev;
  logic            addr_hit;
  logic            cmd_take;
  logic            soft_rst;
  logic [7:0]      rdata;
  logic            push_valid;
  logic            push_ready;
  gpexr_wr_type    push_item;
  logic            pop_valid;
  gpexr_wr_type    pop_item;

  assign scl_rise = state_r.scl_s && !state_r.scl_p;
  assign scl_fall = !state_r.scl_s && state_r.scl_p;
  // Edges of SDA with SCL steady high are conditions, never data.
  assign ev_start = state_r.scl_s && state_r.scl_p && state_r.sda_p && !state_r.sda_s; // see R2 R8
  assign ev_stop  = state_r.scl_s && state_r.scl_p && !state_r.sda_p && state_r.sda_s; // see R9 R8
  assign addr_hit = (state_r.shreg[7:1] == {`GPEXR_ADDR_FIXED, state_r.strap_s}); // see R4
  assign soft_rst = ev_stop && state_r.gc_ok; // see R22
  assign load_ev  = scl_fall && ((state_r.phase == PH_RX_ACK && state_r.kind == K_TX)
                                 || state_r.phase == PH_TX_ACK);
  assign cmd_take = scl_fall && state_r.phase == PH_RX && state_r.kind == K_CMD
                    && state_r.bitcnt == `GPEXR_BYTE_BITS;
  assign push_item = '{slot: slot_of(state_r.ptr), data: state_r.shreg};

  // The drain stalls while a read byte is loaded, so the load never races a write.
  gpexr_fifo #(
    .WIDTH ($bits(gpexr_wr_type)),
    .DEPTH (`GPEXR_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .flush     (soft_rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_item),
    .out_valid (pop_valid),
    .out_ready (!load_ev),
    .out_data  (pop_item)
  );

  always_comb begin
    unique case (state_r.ptr)
      `GPEXR_PIN_LOW:   rdata = state_r.pin_s[7:0]; // see R18 R21
      `GPEXR_PIN_HIGH:  rdata = state_r.pin_s[15:8];
      `GPEXR_IRQ_FLG_L: rdata = irq_flags_in[7:0]; // see R20
      `GPEXR_IRQ_FLG_H: rdata = irq_flags_in[15:8];
      default: begin
        rdata = info_of(state_r.ptr).legal ? state_r.bank[slot_of(state_r.ptr)]
                                           : `GPEXR_ZEROS; // see R15 R19 R25
      end
    endcase
  end

  always_comb begin
    logic ack_ok;
    ack_ok     = 1'b0;
    push_valid = 1'b0;
    state_nxt  = state_r;
    state_nxt.scl_m   = scl_i;
    state_nxt.scl_s   = state_r.scl_m;
    state_nxt.scl_p   = state_r.scl_s;
    state_nxt.sda_m   = sda_i;
    state_nxt.sda_s   = state_r.sda_m;
    state_nxt.sda_p   = state_r.sda_s;
    state_nxt.strap_m = {addr_strap_msb, addr_strap_lsb};
    state_nxt.strap_s = state_r.strap_m;
    state_nxt.pin_m   = {port_one_pins, port_zero_pins};
    state_nxt.pin_s   = state_r.pin_m;
    state_nxt.irq_clr = 2'b00;
    if (pop_valid && !load_ev) begin
      state_nxt.bank[pop_item.slot] = pop_item.data;
    end
    if (ev_start) begin
      // A repeated start also cancels a pending software reset.
      state_nxt.phase    = PH_RX; // see R2
      state_nxt.kind     = K_ADDR;
      state_nxt.bitcnt   = '0;
      state_nxt.sda_pull = 1'b0;
      state_nxt.gc_ok    = 1'b0; // see R22
    end else if (ev_stop) begin
      if (state_r.gc_ok) begin
        state_nxt.bank = BANK_RST; // see R22 R17
        state_nxt.ptr  = `GPEXR_PTR_RESET;
      end
      state_nxt.phase    = PH_IDLE; // see R9
      state_nxt.sda_pull = 1'b0;
      state_nxt.gc_ok    = 1'b0;
    end else begin
      unique case (state_r.phase)
        PH_IDLE, PH_WAIT: begin
          state_nxt.sda_pull = 1'b0;
        end
        PH_RX: begin
          if (scl_rise && state_r.bitcnt != `GPEXR_BYTE_BITS) begin
            state_nxt.shreg  = {state_r.shreg[6:0], state_r.sda_s}; // see R3 R10
            state_nxt.bitcnt = state_r.bitcnt + 4'h1;
          end else if (scl_fall && state_r.bitcnt == `GPEXR_BYTE_BITS) begin
            unique case (state_r.kind)
              K_ADDR: begin
                if (addr_hit) begin
                  ack_ok         = 1'b1; // see R6
                  state_nxt.kind = state_r.shreg[0] ? K_TX : K_CMD; // see R5
                end else if (state_r.shreg == `GPEXR_GCALL_ADDR) begin
                  ack_ok         = 1'b1;
                  state_nxt.kind = K_GC;
                end
              end
              K_CMD: begin
                ack_ok         = 1'b1; // see R12
                state_nxt.ptr  = state_r.shreg; // see R14 R16
                state_nxt.kind = K_DATA;
              end
              K_DATA: begin
                // A full FIFO refuses the byte with a NACK.
                ack_ok     = push_ready; // see R12
                push_valid = push_ready && info_of(state_r.ptr).wr; // see R25
              end
              K_GC: begin
                if (state_r.shreg == `GPEXR_SWRST_BYTE) begin
                  ack_ok          = 1'b1; // see R22
                  state_nxt.gc_ok = 1'b1;
                  state_nxt.kind  = K_GC_DONE;
                end
              end
              K_GC_DONE, K_TX: begin
                state_nxt.gc_ok = 1'b0; // see R22
              end
            endcase
            state_nxt.sda_pull = ack_ok; // see R11
            state_nxt.phase    = ack_ok ? PH_RX_ACK : PH_WAIT;
          end
        end
        PH_RX_ACK: begin
          if (scl_fall) begin
            state_nxt.bitcnt   = '0;
            state_nxt.sda_pull = 1'b0; // see R11
            state_nxt.phase    = PH_RX;
            if (state_r.kind == K_TX) begin
              state_nxt.shreg    = rdata; // see R16
              state_nxt.sda_pull = !rdata[7];
              state_nxt.phase    = PH_TX;
            end
          end
        end
        PH_TX: begin
          if (scl_fall) begin
            if (state_r.bitcnt == `GPEXR_LAST_TX_BIT) begin
              state_nxt.sda_pull = 1'b0; // see R11
              state_nxt.phase    = PH_TX_ACK;
            end else begin
              state_nxt.shreg    = {state_r.shreg[6:0], 1'b0}; // see R3
              state_nxt.bitcnt   = state_r.bitcnt + 4'h1;
              state_nxt.sda_pull = !state_r.shreg[6];
            end
          end
        end
        PH_TX_ACK: begin
          if (scl_rise) begin
            state_nxt.irq_clr[0] = (state_r.ptr == `GPEXR_PIN_LOW); // see R24
            state_nxt.irq_clr[1] = (state_r.ptr == `GPEXR_PIN_HIGH);
            if (state_r.sda_s) begin
              state_nxt.phase = PH_WAIT; // see R13
            end
          end else if (scl_fall) begin
            state_nxt.bitcnt   = '0;
            state_nxt.shreg    = rdata; // see R12
            state_nxt.sda_pull = !rdata[7];
            state_nxt.phase    = PH_TX;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= '{phase: PH_IDLE, kind: K_ADDR, ptr: `GPEXR_PTR_RESET,
                   bank: BANK_RST, scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
                   sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1, default: '0}; // see R23 R17
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sda_o          = 1'b0;
  assign sda_oe         = state_r.sda_pull;
  assign irq_read_clear = state_r.irq_clr;
  assign cfg_out = '{
    drive_value:  {state_r.bank[slot_of(`GPEXR_DRV_VAL_H)], state_r.bank[slot_of(`GPEXR_DRV_VAL_L)]},
    invert:       {state_r.bank[slot_of(`GPEXR_INV_H)], state_r.bank[slot_of(`GPEXR_INV_L)]},
    direction:    {state_r.bank[slot_of(`GPEXR_DIR_H)], state_r.bank[slot_of(`GPEXR_DIR_L)]},
    drive_level:  {state_r.bank[slot_of(`GPEXR_DRV_LVL_D)], state_r.bank[slot_of(`GPEXR_DRV_LVL_C)],
                   state_r.bank[slot_of(`GPEXR_DRV_LVL_B)], state_r.bank[slot_of(`GPEXR_DRV_LVL_A)]},
    hold_input:   {state_r.bank[slot_of(`GPEXR_HOLD_H)], state_r.bank[slot_of(`GPEXR_HOLD_L)]},
    resistor_on:  {state_r.bank[slot_of(`GPEXR_RES_ON_H)], state_r.bank[slot_of(`GPEXR_RES_ON_L)]},
    resistor_dir: {state_r.bank[slot_of(`GPEXR_RES_DIR_H)], state_r.bank[slot_of(`GPEXR_RES_DIR_L)]},
    irq_block:    {state_r.bank[slot_of(`GPEXR_IRQ_BLK_H)], state_r.bank[slot_of(`GPEXR_IRQ_BLK_L)]},
    output_stage_type: state_r.bank[slot_of(`GPEXR_OSTAGE)]
  };

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_byte_end;
    scl_fall && state_r.phase == PH_RX && state_r.bitcnt == `GPEXR_BYTE_BITS;
  endsequence
  sequence s_addr_hit;
    s_byte_end and (state_r.kind == K_ADDR && addr_hit);
  endsequence

  start_to_addr_a: assert property (ev_start |=> state_r.phase == PH_RX // see R2
    && state_r.kind == K_ADDR && state_r.bitcnt == '0 && !state_r.sda_pull)
    else $error("start did not open an address byte");
  addr_ack_drive_a: assert property (s_addr_hit |=> state_r.sda_pull // see R4
    && state_r.phase == PH_RX_ACK)
    else $error("matching address not acknowledged");
  read_dir_bit_a: assert property (s_addr_hit ##0 state_r.shreg[0] |=> state_r.kind == K_TX) // see R5
    else $error("read direction not taken");
  ack_high_hold_a: assert property ((state_r.phase == PH_RX_ACK && state_r.scl_s) // see R6
    |-> state_r.sda_pull)
    else $error("acknowledge released during clock high");
  sda_change_low_a: assert property ($changed(state_r.sda_pull) |-> !state_r.scl_s) // see R8
    else $error("device moved data while clock high");
  stop_to_idle_a: assert property (ev_stop |=> state_r.phase == PH_IDLE && !state_r.sda_pull) // see R9
    else $error("stop did not end the transfer");
  nack_release_a: assert property ((state_r.phase == PH_TX_ACK && scl_rise && state_r.sda_s) // see R13
    |=> state_r.phase == PH_WAIT ##1 !state_r.sda_pull [*2])
    else $error("data line held after controller nack");
  cmd_pointer_a: assert property (cmd_take |=> state_r.ptr == $past(state_r.shreg)) // see R14
    else $error("command byte not stored as pointer");
  pointer_keep_a: assert property ($changed(state_r.ptr) // see R16
    |-> $past(cmd_take) || state_r.ptr == `GPEXR_PTR_RESET)
    else $error("pointer changed without command");
  soft_reset_a: assert property (soft_rst |=> state_r.ptr == `GPEXR_PTR_RESET // see R22
    && state_r.bank == BANK_RST)
    else $error("software reset not applied");
  unmapped_zero_a: assert property ((load_ev && !info_of(state_r.ptr).legal) // see R25
    |=> state_r.shreg == `GPEXR_ZEROS)
    else $error("unmapped register read not zero");
  irq_clear_ack_a: assert property (irq_read_clear[0] |-> $past(state_r.phase == PH_TX_ACK // see R24
    && scl_rise && state_r.ptr == `GPEXR_PIN_LOW))
    else $error("interrupt clear outside input read acknowledge");
endmodule

/* File: test/gpexr_ctl_model.sv */
// Behavioural bus controller driving the clock and the open-drain data line.
`timescale 1ns/1ns
module gpexr_ctl_model (
  // Bus lines
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Low phase of 500 ns leaves room for the responder's 300 ns reaction time.
  task automatic bit_io(input logic b, output logic r);
    #100 sda_low = ~b;
    #400 scl = 1'b1;
    #200 r = sda;
    #100 scl = 1'b0;
  endtask
  // Called only between transfers or as a repeated start, never mid-byte.
  task automatic start();
    if (scl == 1'b0) begin
      #100 sda_low = 1'b0;
      #400 scl = 1'b1;
    end
    #200 sda_low = 1'b1;
    #400 scl = 1'b0;
  endtask
  task automatic stop();
    #100 sda_low = 1'b1;
    #400 scl = 1'b1;
    #200 sda_low = 1'b0;
    #500;
  endtask
  task automatic byte_w(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, nak);
  endtask
  task automatic byte_r(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(last, r);
  endtask
endmodule

/* File: test/gpexr_top_tb.sv */
// Self-checking bench for the I/O expander bus responder.
`timescale 1ns/1ns
module gpexr_top_tb;
  import gpexr_pkg::*;
  localparam gpexr_cfg_type CFG_RST = '{16'hffff, 16'h0000, 16'hffff, 32'hffffffff,
    16'h0000, 16'h0000, 16'hffff, 16'hffff, 8'h00};
  localparam logic [7:0] RW_CODES [19] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4a,
    8'h4b, 8'h4f};
  logic          clk_sys        = 1'b0;
  logic          rst_n          = 1'b0;
  logic          addr_strap_lsb = 1'b0;
  logic          addr_strap_msb = 1'b1;
  logic [7:0]    port_zero_pins = 8'ha5;
  logic [7:0]    port_one_pins  = 8'h3c;
  logic [15:0]   irq_flags_in   = 16'h81c3;
  int            clr_lo         = 0;
  int            clr_hi         = 0;
  logic          scl;
  logic          sda_low;
  logic          sda_o;
  logic          sda_oe;
  wire           sda;
  gpexr_cfg_type cfg_out;
  logic [1:0]    irq_read_clear;
  int            err_total      = 0;
  int            compares       = 0;
  // The data line has a pull-up: it reads low only while some party pulls it.
  assign sda = ~(sda_low | (sda_oe & ~sda_o));
  always #50 clk_sys = ~clk_sys;
  // Clear pulses are counted so that one scenario can see each of them exactly once.
  always @(posedge clk_sys) begin
    clr_lo <= clr_lo + int'(irq_read_clear[0]);
    clr_hi <= clr_hi + int'(irq_read_clear[1]);
  end
  gpexr_ctl_model i_ctl (.scl(scl), .sda_low(sda_low), .sda(sda));
  gpexr_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_strap_lsb(addr_strap_lsb), .addr_strap_msb(addr_strap_msb),
    .port_zero_pins(port_zero_pins), .port_one_pins(port_one_pins),
    .irq_flags_in(irq_flags_in), .cfg_out(cfg_out), .irq_read_clear(irq_read_clear));
  task automatic close_out();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkc(input gpexr_cfg_type got, input gpexr_cfg_type exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] dev(input logic rd);
    return {7'h74 | {5'h00, addr_strap_msb, addr_strap_lsb}, rd};
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d,
                        output logic [2:0] n);
    i_ctl.start();
    i_ctl.byte_w(a, n[2]);
    i_ctl.byte_w(c, n[1]);
    i_ctl.byte_w(d, n[0]);
    i_ctl.stop();
    #1000;
  endtask
  // Two bytes from the current pointer; the controller refuses the second.
  task automatic rd_cur(input logic [7:0] exp);
    logic       n;
    logic [7:0] v;
    i_ctl.start();
    i_ctl.byte_w(dev(1'b1), n);
    i_ctl.byte_r(1'b0, v);
    chk8(v, exp);
    i_ctl.byte_r(1'b1, v);
    chk8(v, exp);
    i_ctl.stop();
  endtask
  task automatic rd_reg(input logic [7:0] c, input logic [7:0] exp);
    logic       n;
    logic [7:0] v;
    i_ctl.start();
    i_ctl.byte_w(dev(1'b0), n);
    i_ctl.byte_w(c, n);
    i_ctl.start();
    i_ctl.byte_w(dev(1'b1), n);
    i_ctl.byte_r(1'b1, v);
    i_ctl.stop();
    chk8(v, exp);
  endtask
  task automatic t_reset();
    @(negedge clk_sys);
    rst_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    chkc(cfg_out, CFG_RST);
    rd_cur(port_zero_pins);
  endtask
  task automatic t_basic();
    logic [2:0] n;
    wr_reg(dev(1'b0), 8'h02, 8'h5a, n);
    chk8({5'h00, n}, 8'h00);
    chk8(cfg_out.drive_value[7:0], 8'h5a);
    rd_cur(8'h5a);
    wr_reg(8'he8, 8'h03, 8'h11, n);
    chk8({7'h00, n[2]}, 8'h01);
    chk8(cfg_out.drive_value[15:8], 8'hff);
  endtask
  task automatic t_map();
    logic [2:0] n;
    int         lo0;
    int         hi0;
    @(negedge clk_sys);
    addr_strap_msb = 1'b0;
    addr_strap_lsb = 1'b1;
    foreach (RW_CODES[i]) begin
      wr_reg(dev(1'b0), RW_CODES[i], RW_CODES[i] ^ 8'h96, n);
      rd_reg(RW_CODES[i], RW_CODES[i] ^ 8'h96);
    end
    chk8(cfg_out.irq_block[7:0], 8'h4a ^ 8'h96);
    wr_reg(dev(1'b0), 8'h00, 8'h00, n);
    lo0 = clr_lo;
    rd_reg(8'h00, port_zero_pins);
    chk8(8'(clr_lo - lo0), 8'h01);
    hi0 = clr_hi;
    rd_reg(8'h01, port_one_pins);
    chk8(8'(clr_hi - hi0), 8'h01);
    chk8(8'(clr_lo - lo0), 8'h01);
    rd_reg(8'h4c, irq_flags_in[7:0]);
    rd_reg(8'h4d, irq_flags_in[15:8]);
    wr_reg(dev(1'b0), 8'h4e, 8'h99, n);
    chk8({5'h00, n}, 8'h00);
    rd_reg(8'h4e, 8'h00);
    rd_reg(8'h08, 8'h00);
  endtask
  task automatic t_swrst();
    logic [2:0] n;
    wr_reg(dev(1'b0), 8'h02, 8'h12, n);
    wr_reg(8'h00, 8'h07, 8'h06, n);
    chk8({5'h00, n}, 8'h03);
    wr_reg(8'h00, 8'h06, 8'h06, n);
    chk8({5'h00, n}, 8'h01);
    chk8(cfg_out.drive_value[7:0], 8'h12);
    i_ctl.start();
    i_ctl.byte_w(8'h00, n[2]);
    i_ctl.byte_w(8'h06, n[1]);
    i_ctl.stop();
    #1000;
    chkc(cfg_out, CFG_RST);
    rd_cur(port_zero_pins);
  endtask
  initial begin
    #4000000;
    err_total++;
    close_out();
  end
  initial begin
    t_reset();
    t_basic();
    t_map();
    t_reset();
    t_swrst();
    close_out();
  end
endmodule
